// [hw/tmrf_register_file.v]
// register file of a three channel temperature monitor: pointer, config,
// conversion timer, results, limits, offsets and status
// assumes a serial front end on the link clock strobes decoded bytes here
//
// Contract
// - default range reports temperatures as plain unsigned binary, one count per degree.
// - extended range reports offset binary, Celsius value plus sixty-four.
// - binary format reports zero for temperatures below zero.
// - binary format saturates results at 127.
// - every register is eight bits wide.
// - local result stored as eight bits for reads and comparison.
// - each new result stored and compared against its high and low limits.
// - first byte of every write loads the pointer, which has no address.
// - second write byte goes to pointed register; reads return pointed register.
// - pointer is zero after reset, so first read returns local result.
// - first config register read at 0x03, written at 0x09.
// - second config register read and written at 0x24.
// - lock bit seven freezes lockable registers until reset; resets to zero.
// - second config bits six to zero are reserved with no function.
// - conversion period read at 0x04, written at 0x0A.
// - low four bits pick period, 16 s at 0x00 to 15.5 ms at 0x0A.
// - code 0x0B converts continuously with no idle time.
// - both status registers are read only.
// - offset split into signed whole byte and fraction byte per remote channel; local has none.
// - fraction byte uses two top bits for quarter degrees, rest zero.
// - any one-shot write starts one conversion in standby; data discarded.
// - config bit three maps shared remote addresses to first or second remote.
`timescale 1ns/1ps
`include "tmrf_regs.vh"

module tmrf_register_file #(
  parameter SHORTEST_CYC = `TMRF_SHORTEST_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // link, from the serial front end (foreign domain)
  input wire linkClk,
  input wire linkByteStb,
  input wire linkFirst,
  input wire [7:0] linkByte,
  input wire linkReadStb,
  // read answer
  output reg [7:0] readData_r,
  output reg readValid_r,
  // measurement side: signed Celsius samples, remote fractions and status inputs
  input wire [9:0] localTemp,
  input wire [9:0] remoteTempA,
  input wire [9:0] remoteTempB,
  input wire [7:0] remoteFracA,
  input wire [7:0] remoteFracB,
  input wire [7:0] statusFirstIn,
  input wire [7:0] statusSecondIn,
  // conversion control and comparison
  output reg convStart_r,
  output reg [2:0] overHigh_r,
  output reg [2:0] underLow_r,
  output wire locked
);

  // ************************************
  // reset release and input synchronisers
  // ************************************
  reg [1:0] rstSync_r;
  wire rstn = rstSync_r[1];

  // reset release through two flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) rstSync_r <= 2'b00;
    else rstSync_r <= {rstSync_r[0], 1'b1};
  end

  reg [2:0] clkSync_r;
  reg [1:0] stbSync_r, firstSync_r, rdSync_r;
  reg [7:0] byteSync0_r, byteSync1_r;

  // two flops on every link input, third for the clock edge detect
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkSync_r <= 3'b000;
      stbSync_r <= 2'b00;
      firstSync_r <= 2'b00;
      rdSync_r <= 2'b00;
      byteSync0_r <= 8'h00;
      byteSync1_r <= 8'h00;
    end else begin
      clkSync_r <= {clkSync_r[1:0], linkClk};
      stbSync_r <= {stbSync_r[0], linkByteStb};
      firstSync_r <= {firstSync_r[0], linkFirst};
      rdSync_r <= {rdSync_r[0], linkReadStb};
      byteSync0_r <= linkByte;
      byteSync1_r <= byteSync0_r;
    end
  end

  // strobes are sampled at the rising link clock edge
  wire linkRise = clkSync_r[1] & ~clkSync_r[2];
  wire byteEvt = linkRise & stbSync_r[1];
  wire ptrEvt = byteEvt & firstSync_r[1];
  wire dataEvt = byteEvt & ~firstSync_r[1];
  wire readEvt = linkRise & rdSync_r[1];

  // ************************************
  // registers
  // ************************************
  reg [7:0] selector_r; // register_selector
  reg [7:0] configFirst_r, convPeriod_r, configSecond_r;
  reg [7:0] locHigh_r, locLow_r;
  reg [7:0] remHigh_r [0:1];
  reg [7:0] remLow_r [0:1];
  reg [7:0] ofsWhole_r [0:1];
  reg [7:0] ofsFrac_r [0:1];
  reg [7:0] locRes_r;
  reg [7:0] remRes_r [0:1];
  reg [7:0] remFracRes_r [0:1];

  assign locked = configSecond_r[`TMRF_LOCK_BIT];
  wire remSel = configFirst_r[`TMRF_CFG_REMOTE_SEL_BIT];
  wire extRange = configFirst_r[`TMRF_CFG_RANGE_BIT];
  wire standby = configFirst_r[`TMRF_CFG_STANDBY_BIT];

  // pointer load from first byte of each write
  always @(posedge clk or negedge rstn) begin
    if (!rstn) selector_r <= `TMRF_RST_SELECTOR;
    else if (ptrEvt) selector_r <= byteSync1_r;
  end

  wire wrEn = dataEvt & ~locked; // locked writes dropped silently
  integer i;

  // host writes at write addresses; read-only and unmapped are ignored
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      configFirst_r <= `TMRF_RST_CONFIG;
      convPeriod_r <= `TMRF_RST_CONV;
      configSecond_r <= `TMRF_RST_CONFIG; // lock clear at reset
      locHigh_r <= `TMRF_RST_HIGH;
      locLow_r <= `TMRF_RST_LOW;
      for (i = 0; i < 2; i = i + 1) begin
        remHigh_r[i] <= `TMRF_RST_HIGH;
        remLow_r[i] <= `TMRF_RST_LOW;
        ofsWhole_r[i] <= 8'h00;
        ofsFrac_r[i] <= 8'h00;
      end
    end else if (wrEn) begin
      if (selector_r == `TMRF_WR_CONFIG_FIRST) begin
        configFirst_r <= byteSync1_r;
      end else if (selector_r == `TMRF_WR_CONV_PERIOD) begin
        convPeriod_r <= byteSync1_r;
      end else if (selector_r == `TMRF_CONFIG_SECOND) begin
        configSecond_r <= {byteSync1_r[`TMRF_LOCK_BIT], 7'h00}; // reserved bits
      end else if (selector_r == `TMRF_WR_LOC_HIGH) begin
        locHigh_r <= byteSync1_r;
      end else if (selector_r == `TMRF_WR_LOC_LOW) begin
        locLow_r <= byteSync1_r;
      end else if (selector_r == `TMRF_WR_REM_HIGH) begin
        remHigh_r[remSel] <= byteSync1_r;
      end else if (selector_r == `TMRF_WR_REM_LOW) begin
        remLow_r[remSel] <= byteSync1_r;
      end else if (selector_r == `TMRF_OFS_WHOLE_A) begin
        ofsWhole_r[0] <= byteSync1_r;
      end else if (selector_r == `TMRF_OFS_FRAC_A) begin
        ofsFrac_r[0] <= byteSync1_r & `TMRF_OFS_FRAC_MASK;
      end else if (selector_r == `TMRF_OFS_WHOLE_B) begin
        ofsWhole_r[1] <= byteSync1_r;
      end else if (selector_r == `TMRF_OFS_FRAC_B) begin
        ofsFrac_r[1] <= byteSync1_r & `TMRF_OFS_FRAC_MASK;
      end
    end
  end

  // ************************************
  // conversion timer
  // ************************************
  // cycles per period: shortest period doubled per code step below 0x0A
  function [31:0] periodCycles;
    input [3:0] code;
    begin
      if (code >= `TMRF_CONV_SHORTEST) periodCycles = SHORTEST_CYC;
      else periodCycles = SHORTEST_CYC << (`TMRF_CONV_SHORTEST - code);
    end
  endfunction

  reg [31:0] convCnt_r;
  wire [3:0] convCode = convPeriod_r[3:0];
  wire oneShot = dataEvt & (selector_r == `TMRF_WR_ONE_SHOT); // data not stored

  // start pulses: timed, continuous, or one shot in standby
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      convCnt_r <= 32'h0000_0000;
      convStart_r <= 1'b0;
    end else if (standby) begin
      convCnt_r <= 32'h0000_0000;
      convStart_r <= oneShot;
    end else if (convCode == `TMRF_CONV_CONTINUOUS || convCode > `TMRF_CONV_CONTINUOUS) begin
      convCnt_r <= 32'h0000_0000;
      convStart_r <= 1'b1; // back to back, no idle
    end else if (convCnt_r + 32'h0000_0001 >= periodCycles(convCode)) begin
      convCnt_r <= 32'h0000_0000;
      convStart_r <= 1'b1;
    end else begin
      convCnt_r <= convCnt_r + 32'h0000_0001;
      convStart_r <= 1'b0;
    end
  end

  // ************************************
  // result formatting and comparison
  // ************************************
  // binary clamps to 0..127, extended adds 64
  function [7:0] formatTemp;
    input [9:0] t;
    input ext;
    reg signed [9:0] v;
    begin
      v = ext ? ($signed(t) + `TMRF_OFFSET_BIAS) : $signed(t);
      if (v < 10'sd0) formatTemp = 8'h00;
      else if (!ext && v > `TMRF_BINARY_MAX) formatTemp = 8'h7F;
      else if (v > 10'sd255) formatTemp = 8'hFF;
      else formatTemp = v[7:0];
    end
  endfunction

  // add whole offset byte, sign extended
  function [9:0] applyOfs;
    input [9:0] t;
    input [7:0] ofs;
    begin
      applyOfs = t + {{2{ofs[7]}}, ofs};
    end
  endfunction

  wire [7:0] locFmt = formatTemp(localTemp, extRange);
  wire [7:0] remFmtA = formatTemp(applyOfs(remoteTempA, ofsWhole_r[0]), extRange);
  wire [7:0] remFmtB = formatTemp(applyOfs(remoteTempB, ofsWhole_r[1]), extRange);

  // latch results and compare on each conversion
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      locRes_r <= 8'h00;
      remRes_r[0] <= 8'h00;
      remRes_r[1] <= 8'h00;
      remFracRes_r[0] <= 8'h00;
      remFracRes_r[1] <= 8'h00;
      overHigh_r <= 3'b000;
      underLow_r <= 3'b000;
    end else if (convStart_r) begin
      locRes_r <= locFmt;
      remRes_r[0] <= remFmtA;
      remRes_r[1] <= remFmtB;
      remFracRes_r[0] <= remoteFracA & `TMRF_OFS_FRAC_MASK;
      remFracRes_r[1] <= remoteFracB & `TMRF_OFS_FRAC_MASK;
      overHigh_r <= {remFmtB > remHigh_r[1], remFmtA > remHigh_r[0], locFmt > locHigh_r};
      underLow_r <= {remFmtB < remLow_r[1], remFmtA < remLow_r[0], locFmt < locLow_r};
    end
  end

  // ************************************
  // read path
  // ************************************
  reg [7:0] rdMux;

  // read decode at read addresses
  always @* begin
    if (selector_r == `TMRF_RD_LOCAL) rdMux = locRes_r;
    else if (selector_r == `TMRF_RD_REMOTE) rdMux = remRes_r[remSel];
    else if (selector_r == `TMRF_RD_STATUS_FIRST) rdMux = statusFirstIn;
    else if (selector_r == `TMRF_RD_CONFIG_FIRST) rdMux = configFirst_r;
    else if (selector_r == `TMRF_RD_CONV_PERIOD) rdMux = convPeriod_r;
    else if (selector_r == `TMRF_RD_LOC_HIGH) rdMux = locHigh_r;
    else if (selector_r == `TMRF_RD_LOC_LOW) rdMux = locLow_r;
    else if (selector_r == `TMRF_RD_REM_HIGH) rdMux = remHigh_r[remSel];
    else if (selector_r == `TMRF_RD_REM_LOW) rdMux = remLow_r[remSel];
    else if (selector_r == `TMRF_RD_REM_FRAC) rdMux = remFracRes_r[remSel];
    else if (selector_r == `TMRF_OFS_WHOLE_A) rdMux = ofsWhole_r[0];
    else if (selector_r == `TMRF_OFS_FRAC_A) rdMux = ofsFrac_r[0];
    else if (selector_r == `TMRF_STATUS_SECOND) rdMux = statusSecondIn;
    else if (selector_r == `TMRF_CONFIG_SECOND) rdMux = configSecond_r;
    else if (selector_r == `TMRF_OFS_WHOLE_B) rdMux = ofsWhole_r[1];
    else if (selector_r == `TMRF_OFS_FRAC_B) rdMux = ofsFrac_r[1];
    else rdMux = 8'h00;
  end

  // read byte held until next read, valid for one cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readData_r <= 8'h00;
      readValid_r <= 1'b0;
    end else begin
      readValid_r <= readEvt;
      if (readEvt) readData_r <= rdMux;
    end
  end

endmodule // tmrf_register_file

// [include/tmrf_regs.vh]
// register map, field positions, reset values and timing counts of the
// temperature monitor register file; assumes a 100 MHz system clock
`ifndef TMRF_REGS_VH
`define TMRF_REGS_VH

// read addresses
`define TMRF_RD_LOCAL 8'h00
`define TMRF_RD_REMOTE 8'h01
`define TMRF_RD_STATUS_FIRST 8'h02
`define TMRF_RD_CONFIG_FIRST 8'h03
`define TMRF_RD_CONV_PERIOD 8'h04
`define TMRF_RD_LOC_HIGH 8'h05
`define TMRF_RD_LOC_LOW 8'h06
`define TMRF_RD_REM_HIGH 8'h07
`define TMRF_RD_REM_LOW 8'h08
`define TMRF_RD_REM_FRAC 8'h10
// write addresses
`define TMRF_WR_CONFIG_FIRST 8'h09
`define TMRF_WR_CONV_PERIOD 8'h0A
`define TMRF_WR_LOC_HIGH 8'h0B
`define TMRF_WR_LOC_LOW 8'h0C
`define TMRF_WR_REM_HIGH 8'h0D
`define TMRF_WR_REM_LOW 8'h0E
`define TMRF_WR_ONE_SHOT 8'h0F
// shared addresses
`define TMRF_OFS_WHOLE_A 8'h11
`define TMRF_OFS_FRAC_A 8'h12
`define TMRF_STATUS_SECOND 8'h23
`define TMRF_CONFIG_SECOND 8'h24
`define TMRF_OFS_WHOLE_B 8'h34
`define TMRF_OFS_FRAC_B 8'h35

// field positions
`define TMRF_LOCK_BIT 7
`define TMRF_CFG_RANGE_BIT 2
`define TMRF_CFG_REMOTE_SEL_BIT 3
`define TMRF_CFG_STANDBY_BIT 6
`define TMRF_OFS_FRAC_MASK 8'hC0

// reset values
`define TMRF_RST_SELECTOR 8'h00
`define TMRF_RST_CONFIG 8'h00
`define TMRF_RST_CONV 8'h07
`define TMRF_RST_HIGH 8'h55
`define TMRF_RST_LOW 8'h00

// format constants
`define TMRF_OFFSET_BIAS 10'sd64
`define TMRF_BINARY_MAX 10'sd127
`define TMRF_CONV_CONTINUOUS 4'hB
`define TMRF_CONV_SHORTEST 4'hA

// timing: clock rate and conversion period of code 0x0A in microseconds
`define TMRF_CLK_MHZ 100
`define TMRF_SHORTEST_US 15500
`define TMRF_SHORTEST_CYC (`TMRF_SHORTEST_US * `TMRF_CLK_MHZ)
`endif

// [tb/tmrf_link_host.sv]
// host model of the serial link: framed bytes on a slow link clock
// assumes the register file samples the link with its own clock
`timescale 1ns/1ps
module tmrf_link_host (
  // system clock
  input wire clk,
  // link towards the register file
  output reg linkClk,
  output reg linkByteStb,
  output reg linkFirst,
  output reg [7:0] linkByte,
  output reg linkReadStb,
  // read answer
  input wire [7:0] readData_r,
  input wire readValid_r,
  output reg timeOut
);
  integer i;
  // link clock parked low between frames
  initial begin
    linkClk = 0;
    linkByteStb = 0;
    linkFirst = 0;
    linkByte = 8'h00;
    linkReadStb = 0;
    timeOut = 0;
  end
  // one event, held through the whole link clock high phase
  task frame(input rdK, input fst, input [7:0] b, output [7:0] d);
    reg got;
    begin
      got = 0;
      d = 8'h00;
      @(posedge clk) #1;
      linkReadStb = rdK;
      linkByteStb = !rdK;
      linkFirst = fst;
      linkByte = b;
      #61.5 linkClk = 1;
      // high phase of about 62 ns; answer sampled just after each edge
      for (i = 0; i < 6; i = i + 1) begin
        @(posedge clk) #1;
        if (rdK && readValid_r === 1'b1) begin
          d = readData_r;
          got = 1;
        end
      end
      #4 linkClk = 0;
      linkReadStb = 0;
      linkByteStb = 0;
      linkByte = ~b; // released byte shows inverse
      if (rdK && !got) timeOut = 1;
    end
  endtask
  // write: pointer byte, then one data byte
  task wr(input [7:0] a, input [7:0] v);
    reg [7:0] x;
    begin
      frame(1'b0, 1'b1, a, x);
      frame(1'b0, 1'b0, v, x);
    end
  endtask
  // read: pointer byte, then one read byte
  task rd(input [7:0] a, output [7:0] d);
    reg [7:0] x;
    begin
      frame(1'b0, 1'b1, a, x);
      frame(1'b1, 1'b0, 8'h00, d);
    end
  endtask
endmodule // tmrf_link_host

// [tb/tmrf_register_file_sva.sv]
// port checker of the register file
// assumes a single clock domain and an active low reset
`timescale 1ns/1ps
module tmrf_register_file_sva #(
  parameter SHORTEST_CYC = 20
) (
  // clock, reset, link
  input wire clk,
  input wire rst_n,
  input wire linkClk,
  input wire linkByteStb,
  input wire linkReadStb,
  // outputs
  input wire [7:0] readData_r,
  input wire readValid_r,
  input wire convStart_r,
  input wire [2:0] overHigh_r,
  input wire [2:0] underLow_r,
  input wire locked
);
  integer gapCnt_r;
  // cycles since the last conversion start
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      gapCnt_r <= 0;
    else if (convStart_r)
      gapCnt_r <= 0;
    else
      gapCnt_r <= gapCnt_r + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_valid_pulse: assert property (readValid_r |=> !readValid_r)
    else $error("read valid wider than one cycle");
  a_data_hold: assert property (!readValid_r |-> $stable(readData_r))
    else $error("read data moved without valid");
  a_read_cause: assert property (readValid_r |-> linkReadStb && !linkByteStb)
    else $error("answer without a read");
  a_read_answer: assert property ($rose(linkClk) && linkReadStb |-> ##[1:7] readValid_r)
    else $error("read not answered");
  a_lock_sticky: assert property (locked |=> locked)
    else $error("lock cleared without reset");
  a_flag_timing: assert property (!$past(convStart_r) && !$past(convStart_r, 2) |->
    $stable(overHigh_r) && $stable(underLow_r))
    else $error("flags moved outside a conversion");
  a_conv_gap: assert property (gapCnt_r <= SHORTEST_CYC * 1024 + 4)
    else $error("conversion period too long");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !locked && !readValid_r && !convStart_r)
    else $error("outputs active in reset");
endmodule // tmrf_register_file_sva
bind tmrf_register_file tmrf_register_file_sva #(.SHORTEST_CYC(SHORTEST_CYC)) tmrf_register_file_sva_inst (
  .clk(clk), .rst_n(rst_n), .linkClk(linkClk), .linkByteStb(linkByteStb), .linkReadStb(linkReadStb),
  .readData_r(readData_r), .readValid_r(readValid_r), .convStart_r(convStart_r), .overHigh_r(overHigh_r),
  .underLow_r(underLow_r), .locked(locked));

// [tb/tmrf_register_file_tb.sv]
// testbench of the register file: register traffic over the link model
// assumes the register map header and a shortened conversion period
`timescale 1ns/1ps
module tmrf_register_file_tb;
  localparam SC = 20;
  reg clk = 0;
  reg rst_n = 1;
  reg [9:0] localTemp = 10'h019;
  reg [9:0] remoteTempA = 10'h014;
  reg [9:0] remoteTempB = 10'h028;
  wire linkClk, linkByteStb, linkFirst, linkReadStb, readValid_r, convStart_r, locked, timeOut;
  wire [7:0] linkByte, readData_r;
  wire [2:0] overHigh_r, underLow_r;
  reg [7:0] d;
  integer nErrors = 0;
  integer nTests = 0;
  integer k;
  reg [9:0] tIn [0:3];
  reg [7:0] tBin [0:3];
  reg [7:0] tExt [0:3];
  // system clock
  always #5 clk = ~clk;
  tmrf_register_file #(.SHORTEST_CYC(SC)) tmrf_register_file_inst (.clk(clk), .rst_n(rst_n), .linkClk(linkClk),
    .linkByteStb(linkByteStb), .linkFirst(linkFirst), .linkByte(linkByte), .linkReadStb(linkReadStb),
    .readData_r(readData_r), .readValid_r(readValid_r), .localTemp(localTemp), .remoteTempA(remoteTempA),
    .remoteTempB(remoteTempB), .remoteFracA(8'hC0), .remoteFracB(8'h40), .statusFirstIn(8'h5A),
    .statusSecondIn(8'hA5), .convStart_r(convStart_r), .overHigh_r(overHigh_r), .underLow_r(underLow_r),
    .locked(locked));
  tmrf_link_host tmrf_link_host_inst (.clk(clk), .linkClk(linkClk), .linkByteStb(linkByteStb),
    .linkFirst(linkFirst), .linkByte(linkByte), .linkReadStb(linkReadStb), .readData_r(readData_r),
    .readValid_r(readValid_r), .timeOut(timeOut));
  task check(input [7:0] seen, input [7:0] exp);
    begin
      nTests = nTests + 1;
      if (seen !== exp) begin
        nErrors = nErrors + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("errors %0d checks %0d", nErrors, nTests);
      if (nErrors == 0 && nTests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    tmrf_link_host_inst.wr(a, v);
  endtask
  task rdChk(input [7:0] a, input [7:0] exp);
    begin
      tmrf_link_host_inst.rd(a, d);
      if (timeOut) begin
        nErrors = nErrors + 1;
        report_and_stop;
      end
      check(d, exp);
    end
  endtask
  task waitConv;
    begin
      repeat (3 * SC) @(posedge clk);
      #1;
    end
  endtask
  // hang guard
  initial begin
    #1000000;
    nErrors = nErrors + 1;
    report_and_stop;
  end
  // main sequence
  initial begin
    tIn[0] = 10'h3C9; tBin[0] = 8'h00; tExt[0] = 8'h09;
    tIn[1] = 10'h000; tBin[1] = 8'h00; tExt[1] = 8'h40;
    tIn[2] = 10'h07F; tBin[2] = 8'h7F; tExt[2] = 8'hBF;
    tIn[3] = 10'h096; tBin[3] = 8'h7F; tExt[3] = 8'hD6;
    #1 rst_n = 0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    repeat (8 * SC + 30) @(posedge clk);
    tmrf_link_host_inst.frame(1'b1, 1'b0, 8'h00, d);
    check(d, 8'h19);
    wr(8'h0A, 8'h0A);
    rdChk(8'h04, 8'h0A);
    for (k = 0; k < 4; k = k + 1) begin
      @(posedge clk) #1 localTemp = tIn[k];
      waitConv;
      rdChk(8'h00, tBin[k]);
    end
    wr(8'h0B, 8'h1E);
    @(posedge clk) #1 localTemp = 10'h028;
    waitConv;
    check({5'h00, overHigh_r}, 8'h01);
    check({5'h00, underLow_r}, 8'h00);
    wr(8'h11, 8'h03);
    wr(8'h12, 8'hC0);
    rdChk(8'h11, 8'h03);
    rdChk(8'h12, 8'hC0);
    waitConv;
    rdChk(8'h01, 8'h17);
    wr(8'h34, 8'h00);
    wr(8'h09, 8'h08);
    waitConv;
    rdChk(8'h01, 8'h28);
    wr(8'h09, 8'h04);
    rdChk(8'h03, 8'h04);
    rdChk(8'h09, 8'h00);
    for (k = 0; k < 4; k = k + 1) begin
      @(posedge clk) #1 localTemp = tIn[k];
      waitConv;
      rdChk(8'h00, tExt[k]);
    end
    wr(8'h02, 8'hFF);
    rdChk(8'h02, 8'h5A);
    wr(8'h23, 8'h00);
    rdChk(8'h23, 8'hA5);
    wr(8'h40, 8'h33);
    rdChk(8'h04, 8'h0A);
    // standby: result frozen until a one-shot write
    wr(8'h09, 8'h44);
    @(posedge clk) #1 localTemp = 10'h00A;
    waitConv;
    rdChk(8'h00, 8'hD6);
    wr(8'h0F, 8'h00);
    rdChk(8'h00, 8'h4A);
    wr(8'h09, 8'h04);
    wr(8'h0A, 8'h0B);
    for (k = 0; k < 5; k = k + 1) begin
      @(posedge clk) #1;
      check({7'h00, convStart_r}, 8'h01);
    end
    wr(8'h0A, 8'h0A);
    wr(8'h24, 8'h80);
    check({7'h00, locked}, 8'h01);
    rdChk(8'h24, 8'h80);
    wr(8'h0A, 8'h05);
    rdChk(8'h04, 8'h0A);
    wr(8'h24, 8'h00);
    check({7'h00, locked}, 8'h01);
    rst_n = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    check({7'h00, locked}, 8'h00);
    repeat (10) @(posedge clk);
    rdChk(8'h04, 8'h07);
    report_and_stop;
  end
endmodule // tmrf_register_file_tb
